// ===== psfc_regs.svh
// Purpose: constants of the program sequencer flow-control block
// Assumes: included by the package and by the design modules
// Notes: opcodes, depth limits and reset values live here
`ifndef PSFC_REGS_SVH
`define PSFC_REGS_SVH

// widths
`define PSFC_LINE_W 16
`define PSFC_VAL_W 32
`define PSFC_NCOND 4
`define PSFC_CDEP_W 4
`define PSFC_STK_AW 3

// depth limits
`define PSFC_CALL_MAX 4'h8
`define PSFC_IF_MAX 8'hff

// command opcodes
`define PSFC_OP_OTHER 3'h0
`define PSFC_OP_IF 3'h1
`define PSFC_OP_ELSE 3'h2
`define PSFC_OP_ENDIF 3'h3
`define PSFC_OP_CALL 3'h4
`define PSFC_OP_END 3'h5
`define PSFC_OP_TRIM 3'h6
`define PSFC_OP_ENTER 3'h7

// condition joins, trim argument bit position
`define PSFC_JOIN_AND 1'h0
`define PSFC_JOIN_OR 1'h1
`define PSFC_TRIM_BIT 0

// reset values and fixed addresses
`define PSFC_AUTO_LINE 16'h0000
`define PSFC_LINE_RST 16'h0000
`define PSFC_CDEP_RST 4'h0
`define PSFC_IDEP_RST 8'h00
`define PSFC_LINE_ONE 16'h0001
`define PSFC_CDEP_ONE 4'h1
`define PSFC_IDEP_ONE 8'h01

`endif

// ===== psfc_pkg.sv
// Purpose: shared types of the flow-control block
// Assumes: constants come from psfc_regs.svh
// Notes: nothing here carries logic
`default_nettype none
`include "psfc_regs.svh"
package psfc_pkg;
   typedef enum logic [1:0] {ST_BOOT, ST_RUN, ST_POP} psfc_state_t;
   typedef logic [2:0] psfc_op_t;
   typedef logic [`PSFC_LINE_W-1:0] psfc_line_t;
endpackage : psfc_pkg
`default_nettype wire

// ===== psfc_stk_if.sv
// Purpose: carrier between the sequencer and its return-line stack
// Assumes: one clock, owned by the sequencer
// Notes: read data arrives one cycle after the read address
`timescale 1ns/1ns
`default_nettype none
`include "psfc_regs.svh"
interface psfc_stk_if;
   logic wr_en;
   logic [`PSFC_STK_AW-1:0] wr_addr;
   psfc_pkg::psfc_line_t wr_data;
   logic [`PSFC_STK_AW-1:0] rd_addr;
   psfc_pkg::psfc_line_t rd_data;
   modport owner (output wr_en, output wr_addr, output wr_data, output rd_addr, input rd_data);
   modport mem (input wr_en, input wr_addr, input wr_data, input rd_addr, output rd_data);
endinterface : psfc_stk_if
`default_nettype wire

// ===== psfc_stack_mem.sv
// Purpose: eight-entry memory of return lines
// Assumes: single clock, synchronous reset
// Notes: read data is registered, so it lags the address by one cycle
`timescale 1ns/1ns
`default_nettype none
`include "psfc_regs.svh"
module psfc_stack_mem (
   input wire logic clk, // controller clock
   input wire logic rst, // synchronous reset, active high
   psfc_stk_if.mem stk // write and read ports
);
   psfc_pkg::psfc_line_t mem_q [0:(1<<`PSFC_STK_AW)-1];
   psfc_pkg::psfc_line_t rd_ff;

   // storage write
   always_ff @(posedge clk) begin
      if (stk.wr_en) begin
         mem_q[stk.wr_addr] <= stk.wr_data;
      end
   end

   // registered read
   always_ff @(posedge clk) begin
      if (rst) begin
         rd_ff <= `PSFC_LINE_RST;
      end else begin
         rd_ff <= mem_q[stk.rd_addr];
      end
   end

   assign stk.rd_data = rd_ff;
endmodule : psfc_stack_mem
`default_nettype wire

// ===== psfc_seq.sv
// Purpose: flow control of a stored-program command sequencer
// Assumes: one command per accepted handshake, conditions already evaluated to numbers
// Notes: skipped commands are absorbed here, executable ones are passed on by a pulse
`timescale 1ns/1ns
`default_nettype none
`include "psfc_regs.svh"
module psfc_seq (
   input wire logic REF_CLK, // 25 MHz controller clock
   input wire logic SYS_RST, // synchronous reset, active high
   input wire logic AUTO_PRESENT, // stored program opens with the auto-start label
   input wire logic CMD_VALID, // command offered
   input wire logic [2:0] CMD_OP, // command opcode
   input wire logic [7:0] CMD_ARG, // small numeric argument (trim level)
   input wire logic [`PSFC_LINE_W-1:0] CMD_LINE, // line of this command
   input wire logic [`PSFC_LINE_W-1:0] CMD_DEST, // destination line of call or routine
   input wire logic [`PSFC_NCOND*`PSFC_VAL_W-1:0] CMD_COND, // condition values, first in low word
   input wire logic [2:0] CMD_NCOND, // number of conditions, zero means none
   input wire logic [`PSFC_NCOND-2:0] CMD_JOIN, // join before condition i+1, 1 = or
   output logic CMD_READY, // command can be taken
   output logic EXEC, // pass an ordinary command on for execution
   output logic JUMP, // redirect program fetch
   output logic [`PSFC_LINE_W-1:0] JUMP_ADDR, // line to fetch next
   output logic ERR, // command error pulse
   output logic RUN, // program running
   output logic [`PSFC_CDEP_W-1:0] CALL_DEPTH, // return stack depth
   output logic [7:0] IF_DEPTH, // open conditional blocks
   output logic SKIPPING // commands are being skipped
);
   psfc_pkg::psfc_state_t state_ff, nxt_state;
   logic ready_ff, nxt_ready;
   logic exec_ff, jump_ff, err_ff, run_ff, skip_ff, else_ok_ff;
   logic nxt_exec, nxt_jump, nxt_err, nxt_run, nxt_skip, nxt_else_ok;
   psfc_pkg::psfc_line_t jaddr_ff, nxt_jaddr;
   logic [`PSFC_CDEP_W-1:0] cdep_ff, nxt_cdep;
   logic [7:0] idep_ff, nxt_idep, slvl_ff, nxt_slvl;
   psfc_stk_if stk ();
   psfc_stack_mem u_mem (
      .clk(REF_CLK),
      .rst(SYS_RST),
      .stk(stk)
   );
   // conditions: nonzero is true, joined left to right
   function automatic logic psfc_cond(input logic [`PSFC_NCOND*`PSFC_VAL_W-1:0] vals,
                                      input logic [2:0] n, input logic [`PSFC_NCOND-2:0] joins);
      logic acc, term;
      acc = 1'b1;
      if (n != 3'h0) begin
         acc = (vals[`PSFC_VAL_W-1:0] != '0);
      end
      for (int i = 1; i < `PSFC_NCOND; i++) begin
         term = (vals[i*`PSFC_VAL_W +: `PSFC_VAL_W] != '0);
         if (3'(i) < n) begin
            acc = (joins[i-1] == `PSFC_JOIN_OR) ? (acc | term) : (acc & term);
         end
      end
      return acc;
   endfunction : psfc_cond
   // command decode
   wire accept = CMD_VALID & ready_ff & (state_ff == psfc_pkg::ST_RUN);
   wire live = ~skip_ff;
   wire cond = psfc_cond(CMD_COND, CMD_NCOND, CMD_JOIN);
   wire is_other = accept & (CMD_OP == `PSFC_OP_OTHER);
   wire is_if = accept & (CMD_OP == `PSFC_OP_IF);
   wire is_else = accept & (CMD_OP == `PSFC_OP_ELSE);
   wire is_endif = accept & (CMD_OP == `PSFC_OP_ENDIF);
   wire is_call = accept & (CMD_OP == `PSFC_OP_CALL) & live;
   wire is_end = accept & (CMD_OP == `PSFC_OP_END) & live;
   wire is_trim = accept & (CMD_OP == `PSFC_OP_TRIM) & live;
   wire is_enter = accept & (CMD_OP == `PSFC_OP_ENTER);
   wire call_full = (cdep_ff == `PSFC_CALL_MAX);
   wire call_empty = (cdep_ff == `PSFC_CDEP_RST);
   wire call_go = is_call & cond;
   wire push_req = call_go | is_enter;
   wire push_ok = push_req & ~call_full;
   wire pop_ok = is_end & ~call_empty;
   wire halt = is_end & call_empty;
   wire trim_one = is_trim & CMD_ARG[`PSFC_TRIM_BIT];
   wire trim_zero = is_trim & ~CMD_ARG[`PSFC_TRIM_BIT];
   // conditional nesting decode
   wire [8:0] nest_sum = {1'b0, idep_ff} + {1'b0, slvl_ff};
   wire if_full = (nest_sum >= {1'b0, `PSFC_IF_MAX});
   wire if_none = (idep_ff == `PSFC_IDEP_RST);
   wire slvl_zero = (slvl_ff == `PSFC_IDEP_RST);
   wire cmd_err = (push_req & call_full) | (is_if & if_full) | (trim_one & call_empty)
                  | ((is_else | is_endif) & live & if_none);
   // stack ports: push at current depth, always read the top entry
   assign stk.wr_en = push_ok;
   assign stk.wr_addr = cdep_ff[`PSFC_STK_AW-1:0];
   assign stk.wr_data = is_enter ? CMD_LINE : psfc_pkg::psfc_line_t'(CMD_LINE + `PSFC_LINE_ONE);
   assign stk.rd_addr = cdep_ff[`PSFC_STK_AW-1:0] - `PSFC_STK_AW'(1);
   // next state of the sequencer
   always_comb begin
      nxt_state = state_ff;
      nxt_ready = ready_ff;
      nxt_exec = is_other & live;
      nxt_jump = 1'b0;
      nxt_jaddr = jaddr_ff;
      nxt_err = cmd_err;
      nxt_run = run_ff;
      nxt_skip = skip_ff;
      nxt_else_ok = else_ok_ff;
      nxt_cdep = cdep_ff;
      nxt_idep = idep_ff;
      nxt_slvl = slvl_ff;
      case (state_ff)
         psfc_pkg::ST_BOOT: begin
            nxt_state = psfc_pkg::ST_RUN;
            nxt_ready = 1'b1;
            nxt_run = AUTO_PRESENT;
            nxt_jump = AUTO_PRESENT;
            nxt_jaddr = `PSFC_AUTO_LINE;
         end
         psfc_pkg::ST_POP: begin
            nxt_state = psfc_pkg::ST_RUN;
            nxt_ready = 1'b1;
            nxt_jump = 1'b1;
            nxt_jaddr = stk.rd_data;
            nxt_cdep = cdep_ff - `PSFC_CDEP_ONE;
         end
         psfc_pkg::ST_RUN: begin
            if (push_ok) begin
               nxt_cdep = cdep_ff + `PSFC_CDEP_ONE;
               nxt_jump = 1'b1;
               nxt_jaddr = CMD_DEST;
               nxt_run = 1'b1;
            end
            if (pop_ok) begin
               nxt_state = psfc_pkg::ST_POP;
               nxt_ready = 1'b0;
            end
            if (halt) begin
               nxt_run = 1'b0;
            end
            if (trim_one & ~call_empty) begin
               nxt_cdep = cdep_ff - `PSFC_CDEP_ONE;
            end
            if (trim_zero) begin
               nxt_cdep = `PSFC_CDEP_RST;
            end
            if (is_if & live & ~if_full) begin
               nxt_idep = idep_ff + `PSFC_IDEP_ONE;
               nxt_skip = ~cond;
               nxt_else_ok = 1'b1;
            end
            if (is_if & skip_ff & ~if_full) begin
               nxt_slvl = slvl_ff + `PSFC_IDEP_ONE;
            end
            if (is_else & live & ~if_none) begin
               nxt_skip = 1'b1;
               nxt_else_ok = 1'b0;
            end
            if (is_else & skip_ff & slvl_zero & else_ok_ff) begin
               nxt_skip = 1'b0;
            end
            if (is_endif & live & ~if_none) begin
               nxt_idep = idep_ff - `PSFC_IDEP_ONE;
            end
            if (is_endif & skip_ff) begin
               if (slvl_zero) begin
                  nxt_skip = 1'b0;
                  nxt_idep = idep_ff - `PSFC_IDEP_ONE;
               end else begin
                  nxt_slvl = slvl_ff - `PSFC_IDEP_ONE;
               end
            end
         end
         default: nxt_state = psfc_pkg::ST_BOOT;
      endcase
   end
   // control registers
   always_ff @(posedge REF_CLK) begin
      if (SYS_RST) begin
         state_ff <= psfc_pkg::ST_BOOT;
         ready_ff <= 1'b0;
         exec_ff <= 1'b0;
         jump_ff <= 1'b0;
         jaddr_ff <= `PSFC_LINE_RST;
         err_ff <= 1'b0;
         run_ff <= 1'b0;
         skip_ff <= 1'b0;
         else_ok_ff <= 1'b0;
      end else begin
         state_ff <= nxt_state;
         ready_ff <= nxt_ready;
         exec_ff <= nxt_exec;
         jump_ff <= nxt_jump;
         jaddr_ff <= nxt_jaddr;
         err_ff <= nxt_err;
         run_ff <= nxt_run;
         skip_ff <= nxt_skip;
         else_ok_ff <= nxt_else_ok;
      end
   end
   // depth counters
   always_ff @(posedge REF_CLK) begin
      if (SYS_RST) begin
         cdep_ff <= `PSFC_CDEP_RST;
         idep_ff <= `PSFC_IDEP_RST;
         slvl_ff <= `PSFC_IDEP_RST;
      end else begin
         cdep_ff <= nxt_cdep;
         idep_ff <= nxt_idep;
         slvl_ff <= nxt_slvl;
      end
   end
   assign CMD_READY = ready_ff;
   assign EXEC = exec_ff;
   assign JUMP = jump_ff;
   assign JUMP_ADDR = jaddr_ff;
   assign ERR = err_ff;
   assign RUN = run_ff;
   assign CALL_DEPTH = cdep_ff;
   assign IF_DEPTH = idep_ff;
   assign SKIPPING = skip_ff;
   // checks on the flow decisions
   property p_if_true;
      @(posedge REF_CLK) disable iff (SYS_RST) (is_if & live & ~if_full & cond) |=> !SKIPPING;
   endproperty
   a_if_true: assert property (p_if_true) else $error("true opener did not execute on");
   property p_if_false;
      @(posedge REF_CLK) disable iff (SYS_RST)
         (is_if & live & ~if_full & ~cond) |=> SKIPPING && IF_DEPTH == $past(idep_ff) + 8'h01;
   endproperty
   a_if_false: assert property (p_if_false) else $error("false opener did not skip");
   property p_else_resume;
      @(posedge REF_CLK) disable iff (SYS_RST) (is_else & skip_ff & slvl_zero & else_ok_ff) |=> !SKIPPING;
   endproperty
   a_else_resume: assert property (p_else_resume) else $error("else did not resume");
   property p_if_full;
      @(posedge REF_CLK) disable iff (SYS_RST) (is_if & if_full) |=> ERR && $stable(IF_DEPTH);
   endproperty
   a_if_full: assert property (p_if_full) else $error("nesting overflow not flagged");
   property p_call;
      @(posedge REF_CLK) disable iff (SYS_RST)
         (call_go & ~call_full) |=> JUMP && JUMP_ADDR == $past(CMD_DEST) && CALL_DEPTH == $past(cdep_ff) + 4'h1;
   endproperty
   a_call: assert property (p_call) else $error("call did not push and jump");
   property p_return;
      @(posedge REF_CLK) disable iff (SYS_RST)
         pop_ok |=> !CMD_READY ##1 (JUMP && CALL_DEPTH == $past(cdep_ff, 2) - 4'h1);
   endproperty
   a_return: assert property (p_return) else $error("end did not return");
   property p_trim_one;
      @(posedge REF_CLK) disable iff (SYS_RST)
         (trim_one & ~call_empty) |=> !JUMP && CALL_DEPTH == $past(cdep_ff) - 4'h1;
   endproperty
   a_trim_one: assert property (p_trim_one) else $error("trim one misbehaved");
   property p_trim_zero;
      @(posedge REF_CLK) disable iff (SYS_RST) trim_zero |=> CALL_DEPTH == 4'h0;
   endproperty
   a_trim_zero: assert property (p_trim_zero) else $error("trim zero did not empty");
   property p_auto;
      @(posedge REF_CLK) disable iff (SYS_RST)
         (!SYS_RST && state_ff == psfc_pkg::ST_BOOT && AUTO_PRESENT) |=> RUN && JUMP && JUMP_ADDR == `PSFC_AUTO_LINE;
   endproperty
   a_auto: assert property (p_auto) else $error("auto-start missed");
   property p_call_full;
      @(posedge REF_CLK) disable iff (SYS_RST) (push_req & call_full) |=> ERR && CALL_DEPTH == `PSFC_CALL_MAX && !JUMP;
   endproperty
   a_call_full: assert property (p_call_full) else $error("stack overflow not refused");
endmodule : psfc_seq
`default_nettype wire

// ===== psfc_host_model.sv
// Purpose: command source standing in for the host and the stored program memory
// Assumes: one command offered at a time, held until the sequencer takes it or 64 cycles pass
// Notes: released lines show the inverse of their last value, so stale data never looks valid
`timescale 1ns/1ns
`default_nettype none
`include "psfc_regs.svh"
module psfc_host_model (
   input wire logic clk, // controller clock
   input wire logic ready, // sequencer can take a command
   output logic valid, // command offered
   output logic [2:0] op, // opcode
   output logic [7:0] arg, // trim level
   output logic [15:0] line, // line of this command
   output logic [15:0] dest, // call destination
   output logic [127:0] cond, // condition values
   output logic [2:0] ncond, // number of conditions
   output logic [2:0] joins, // condition joins
   output logic stall // a command was never taken
);
   // idle values at time zero
   initial begin
      valid = 1'b0;
      op = 3'h0;
      arg = 8'h00;
      line = 16'h0000;
      dest = 16'h0000;
      cond = 128'h0;
      ncond = 3'h0;
      joins = 3'h0;
      stall = 1'b0;
   end

   // offer one command after gap idle cycles, hold it until taken or for at most 64 cycles, then release
   // else carries no arguments
   task automatic send(input logic [2:0] o, input logic [7:0] a, input logic [15:0] l, input logic [15:0] d,
      input logic [127:0] c, input logic [2:0] n, input logic [2:0] j, input int gap);
      int k;
      repeat (gap) @(posedge clk);
      @(posedge clk);
      valid <= 1'b1;
      op <= o;
      arg <= (o == `PSFC_OP_ELSE) ? 8'h00 : a;
      line <= l;
      dest <= d;
      cond <= (o == `PSFC_OP_ELSE) ? 128'h0 : c;
      ncond <= (o == `PSFC_OP_ELSE) ? 3'h0 : n;
      joins <= j;
      for (k = 0; k < 64; k++) begin
         @(posedge clk);
         if (ready) break;
      end
      if (k == 64) stall <= 1'b1;
      valid <= 1'b0;
      op <= ~o;
      arg <= ~a;
      line <= ~l;
      dest <= ~d;
      cond <= ~c;
      ncond <= ~n;
      joins <= ~j;
   endtask : send
endmodule : psfc_host_model
`default_nettype wire

// ===== psfc_tb.sv
// Purpose: self-checking bench of the flow-control sequencer
// Assumes: host model offers commands, bench judges the registered answers
// Notes: each scenario is its own task and reports when it ends
`timescale 1ns/1ns
`default_nettype none
`include "psfc_regs.svh"
`define CHK(g, e, m) begin n_checks++; if ((g) !== (e)) begin error_cnt++; $display("unexpected at %0t: %s", $time, m); end end
module testbench;
   logic ref_clk = 1'b0;
   logic sys_rst = 1'b1;
   logic auto_present = 1'b1; // program burned with auto label
   int error_cnt = 0;
   int n_checks = 0;
   wire logic valid, ready, exec, jump, err, run, skipping, stall;
   wire logic [2:0] op, ncond, joins;
   wire logic [7:0] arg, if_depth;
   wire logic [15:0] line, dest, jump_addr;
   wire logic [127:0] cond;
   wire logic [3:0] call_depth;

   // 25 MHz clock
   always #20 ref_clk = ~ref_clk;

   psfc_seq psfc_seq_inst (.REF_CLK(ref_clk), .SYS_RST(sys_rst), .AUTO_PRESENT(auto_present), .CMD_VALID(valid),
      .CMD_OP(op), .CMD_ARG(arg), .CMD_LINE(line), .CMD_DEST(dest), .CMD_COND(cond), .CMD_NCOND(ncond),
      .CMD_JOIN(joins), .CMD_READY(ready), .EXEC(exec), .JUMP(jump), .JUMP_ADDR(jump_addr), .ERR(err),
      .RUN(run), .CALL_DEPTH(call_depth), .IF_DEPTH(if_depth), .SKIPPING(skipping));
   psfc_host_model psfc_host_model_inst (.clk(ref_clk), .ready(ready), .valid(valid), .op(op), .arg(arg),
      .line(line), .dest(dest), .cond(cond), .ncond(ncond), .joins(joins), .stall(stall));

   // move to just after the next edge, where outputs have settled
   task automatic step;
      @(posedge ref_clk);
      #1;
   endtask : step

   // one command, then land in the answer cycle
   task automatic cmd(input logic [2:0] o, input logic [15:0] l, input logic [15:0] d, input logic [95:0] cv,
      input logic [2:0] n, input logic [2:0] j);
      psfc_host_model_inst.send(o, cv[7:0], l, d, {32'h0, cv}, n, j, 0);
      #1;
   endtask : cmd

   task automatic simple(input logic [2:0] o);
      cmd(o, 16'h0000, 16'h0000, 96'h0, 3'h0, 3'h0);
   endtask : simple

   task automatic t_boot;
      repeat (6) @(posedge ref_clk);
      sys_rst <= 1'b0;
      step();
      `CHK(ready, 1'b1, "ready after boot")
      `CHK(jump, 1'b1, "auto start jump")
      `CHK(jump_addr, `PSFC_AUTO_LINE, "auto start line")
      `CHK(run, 1'b1, "auto start run")
      step();
      `CHK(jump, 1'b0, "jump pulse length")
      $display("test boot done");
   endtask : t_boot

   task automatic t_if_true_else;
      cmd(`PSFC_OP_IF, 16'h0100, 16'h0000, 96'h8000_0000, 3'h1, 3'h0);
      `CHK(skipping, 1'b0, "true opener skips")
      `CHK(if_depth, 8'h01, "opener depth")
      simple(`PSFC_OP_OTHER);
      `CHK(exec, 1'b1, "body not run")
      simple(`PSFC_OP_ELSE);
      `CHK(skipping, 1'b1, "else part not skipped")
      simple(`PSFC_OP_OTHER);
      `CHK(exec, 1'b0, "else part run")
      simple(`PSFC_OP_ENDIF);
      `CHK(skipping, 1'b0, "skip after end-if")
      `CHK(if_depth, 8'h00, "depth after end-if")
      $display("test if_true_else done");
   endtask : t_if_true_else

   task automatic t_if_false_else;
      cmd(`PSFC_OP_IF, 16'h0200, 16'h0000, 96'h0, 3'h1, 3'h0);
      `CHK(skipping, 1'b1, "false opener runs")
      cmd(`PSFC_OP_IF, 16'h0201, 16'h0000, 96'h1, 3'h1, 3'h0);
      simple(`PSFC_OP_ELSE);
      `CHK(skipping, 1'b1, "inner else ends skip")
      cmd(`PSFC_OP_CALL, 16'h0203, 16'h0300, 96'h0, 3'h0, 3'h0);
      `CHK(jump, 1'b0, "skipped call jumps")
      `CHK(call_depth, 4'h0, "skipped call pushes")
      simple(`PSFC_OP_ENDIF);
      `CHK(skipping, 1'b1, "inner end-if ends skip")
      simple(`PSFC_OP_ELSE);
      `CHK(skipping, 1'b0, "outer else keeps skip")
      simple(`PSFC_OP_OTHER);
      `CHK(exec, 1'b1, "else part not run")
      simple(`PSFC_OP_ENDIF);
      `CHK(if_depth, 8'h00, "depth after end-if")
      $display("test if_false_else done");
   endtask : t_if_false_else

   task automatic t_join;
      logic [95:0] cvs [4] = '{96'h0_00000000_00000001, 96'h5_00000000_00000000, 96'h0, 96'h0_00000004_00000003};
      logic [2:0] ns [4] = '{3'h3, 3'h3, 3'h0, 3'h2};
      logic [2:0] js [4] = '{3'h1, 3'h2, 3'h0, 3'h0};
      logic skips [4] = '{1'b1, 1'b0, 1'b0, 1'b0};
      for (int i = 0; i < 4; i++) begin
         cmd(`PSFC_OP_IF, 16'h0400, 16'h0000, cvs[i], ns[i], js[i]);
         `CHK(skipping, skips[i], "joined condition result")
         simple(`PSFC_OP_ENDIF);
      end
      $display("test join done");
   endtask : t_join

   task automatic t_call_end;
      cmd(`PSFC_OP_CALL, 16'h0010, 16'h0040, 96'h0, 3'h0, 3'h0);
      `CHK(jump_addr, 16'h0040, "call target")
      `CHK(call_depth, 4'h1, "call push")
      cmd(`PSFC_OP_CALL, 16'h0050, 16'h0060, 96'h0, 3'h1, 3'h0);
      `CHK(jump, 1'b0, "false call jumped")
      simple(`PSFC_OP_END);
      `CHK(ready, 1'b0, "ready after popping end")
      step();
      `CHK(jump_addr, 16'h0011, "return line")
      `CHK(call_depth, 4'h0, "end pop")
      psfc_host_model_inst.send(`PSFC_OP_ENTER, 8'h00, 16'h0020, 16'h0080, 128'h0, 3'h0, 3'h0, 3);
      #1;
      `CHK(jump, 1'b1, "routine jump")
      `CHK(jump_addr, 16'h0080, "routine target")
      `CHK(call_depth, 4'h1, "routine push")
      simple(`PSFC_OP_END);
      step();
      `CHK(jump_addr, 16'h0020, "routine resume line")
      $display("test call_end done");
   endtask : t_call_end

   task automatic t_call_limits;
      for (int i = 0; i < 8; i++) cmd(`PSFC_OP_CALL, 16'h0100 + 16'(i), 16'h0500, 96'h0, 3'h0, 3'h0);
      `CHK(call_depth, 4'h8, "eight levels")
      cmd(`PSFC_OP_CALL, 16'h01ff, 16'h0600, 96'h0, 3'h0, 3'h0);
      `CHK(err, 1'b1, "ninth call accepted")
      `CHK(call_depth, 4'h8, "overflow changed depth")
      simple(`PSFC_OP_END);
      step();
      `CHK(jump_addr, 16'h0108, "stack corrupted")
      cmd(`PSFC_OP_TRIM, 16'h0000, 16'h0000, 96'h1, 3'h0, 3'h0);
      `CHK(call_depth, 4'h6, "trim one")
      `CHK(jump, 1'b0, "trim one jumped")
      simple(`PSFC_OP_OTHER);
      `CHK(exec, 1'b1, "no next line after trim")
      cmd(`PSFC_OP_TRIM, 16'h0000, 16'h0000, 96'h0, 3'h0, 3'h0);
      `CHK(call_depth, 4'h0, "trim zero")
      simple(`PSFC_OP_END);
      `CHK(run, 1'b0, "end on empty stack")
      $display("test call_limits done");
   endtask : t_call_limits

   task automatic t_if_depth;
      for (int i = 0; i < 255; i++) cmd(`PSFC_OP_IF, 16'h0700, 16'h0000, 96'h1, 3'h1, 3'h0);
      `CHK(if_depth, 8'hff, "255 levels")
      cmd(`PSFC_OP_IF, 16'h0701, 16'h0000, 96'h1, 3'h1, 3'h0);
      `CHK(err, 1'b1, "256th opener accepted")
      `CHK(if_depth, 8'hff, "overflow changed depth")
      for (int i = 0; i < 255; i++) simple(`PSFC_OP_ENDIF);
      `CHK(if_depth, 8'h00, "unwound depth")
      simple(`PSFC_OP_ENDIF);
      `CHK(err, 1'b1, "stray end-if accepted")
      $display("test if_depth done");
   endtask : t_if_depth

   // mid-run reset with no auto-start label stored
   task automatic t_no_auto;
      cmd(`PSFC_OP_CALL, 16'h0800, 16'h0900, 96'h0, 3'h0, 3'h0);
      @(posedge ref_clk);
      sys_rst <= 1'b1;
      auto_present <= 1'b0;
      repeat (6) @(posedge ref_clk);
      sys_rst <= 1'b0;
      step();
      `CHK(ready, 1'b1, "ready after reset")
      `CHK(jump, 1'b0, "start without auto label")
      `CHK(run, 1'b0, "run without auto label")
      `CHK(jump_addr, `PSFC_LINE_RST, "jump line after reset")
      `CHK(call_depth, `PSFC_CDEP_RST, "depth after reset")
      $display("test no_auto done");
   endtask : t_no_auto

   // verdict and end of run
   task automatic wrap_up;
      $display("checks %0d mismatches %0d", n_checks, error_cnt);
      if (error_cnt == 0 && n_checks > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : wrap_up

   // main sequence, jumps kept outside conditional blocks
   initial begin
      t_boot();
      t_if_true_else();
      t_if_false_else();
      t_join();
      t_call_end();
      t_call_limits();
      t_if_depth();
      t_no_auto();
      `CHK(stall, 1'b0, "command never taken")
      wrap_up();
   end

   // watchdog well beyond the roughly 1100 cycles the tests need
   initial begin
      repeat (10000) @(posedge ref_clk);
      error_cnt++;
      $display("unexpected at %0t: watchdog expired", $time);
      wrap_up();
   end
endmodule : testbench
`default_nettype wire
